//--- design/flash_seq_cfg.svh
// Purpose: Constants for the flash self-program sequencer and its controller
// Assumes: 16K byte array, byte wide special function registers
// Notes: Rules of the sequencer follow
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH
`define SFR_ACCESS_CONTROL 3'h0
`define SFR_MODE_SELECT 3'h1
`define SFR_ADDR_HIGH 3'h2
`define SFR_ADDR_LOW 3'h3
`define SFR_DATA 3'h4
`define SFR_COMMAND_KEY 3'h5
`define SFR_LOW_BOUND 3'h6
`define ENABLE_BIT 7
`define MODE_ERASE 3'h3
`define MODE_PROGRAM 3'h2
`define MODE_READ 3'h1
`define KEY_FIRST 8'h46
`define KEY_SECOND 8'hB9
`define FLASH_BYTES 17'h04000
`define PAGE_BITS 9
`define ADDR_BITS 14
`define OP_CYCLES 4'h4
`define APB_SFR_WRITE 8'h00
`define APB_SFR_READ 8'h04
`define APB_STATUS 8'h08
`define APB_CONTROL 8'h0C
`endif

//--- design/flash_seq_dev.sv
// Purpose: Flash self-program sequencer with its own array
// Assumes: CPU issues no register access while stalled
// Notes: Low bound holds address bits 13..8
//
// The APB interface to the registers and the register offsets were decided locally.
`include "flash_seq_cfg.svh"
`timescale 1ns/1ps
module flash_seq_dev #(
   parameter int ADDR_W = `ADDR_BITS
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   flash_sfr_if.dev sfr,
   input wire logic [3:0] loader_size_opt,
   input wire logic [5:0] low_bound_opt,
   input wire logic irq_req,
   output logic irq_take
);
   // Array shared by all three regions
   logic [7:0] mem [0:(1 << ADDR_W) - 1];

   logic [7:0] ctrl_r, ctrl_nxt;
   logic [2:0] mode_r, mode_nxt;
   logic [7:0] adr_hi_r, adr_hi_nxt;
   logic [7:0] adr_lo_r, adr_lo_nxt;
   logic [7:0] data_r, data_nxt;
   logic [5:0] low_bound_r, low_bound_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic strap_done_r, strap_done_nxt;
   flash_seq_pkg::seq_state_t state_r, state_nxt;
   logic [`PAGE_BITS-1:0] cnt_r, cnt_nxt;
   logic trigger;
   logic [15:0] target;
   logic [15:0] eff_addr;
   logic [16:0] loader_start;
   logic [16:0] low_start;
   logic in_range;
   logic mem_we;
   logic [ADDR_W-1:0] mem_addr;
   logic [7:0] mem_wdata;

   key_unlock i_key_unlock (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .key_wr(sfr.sfr_wr && sfr.sfr_addr == `SFR_COMMAND_KEY && state_r == flash_seq_pkg::ST_IDLE),
      .key_data(sfr.sfr_wdata),
      .enable(ctrl_r[`ENABLE_BIT]),
      .trigger(trigger)
   );

   assign target = {adr_hi_r, adr_lo_r};
   // Loader sits at the top, 512 bytes per option step; zero means none
   assign loader_start = `FLASH_BYTES - {4'h0, loader_size_opt, 9'h000};
   // Option only seeds the register at reset; software may move it later
   assign low_start = {3'h0, low_bound_r, 8'h00};

   // Erase touches a whole page, so range tests use the page start
   function automatic logic [15:0] op_addr(input logic [2:0] mode, input logic [15:0] addr);
      logic [15:0] base;
      base = addr;
      if (mode == `MODE_ERASE) begin
         base[`PAGE_BITS-1:0] = '0;
      end
      return base;
   endfunction

   // Program and read share one fixed access length
   function automatic logic op_done(input logic [`PAGE_BITS-1:0] cnt);
      return cnt == {5'h00, `OP_CYCLES};
   endfunction

   assign eff_addr = op_addr(mode_r, target);

   // Data region ends just below the loader
   always_comb begin
      in_range = ({1'b0, eff_addr} < loader_start);
      // A sloppy erase address must not reach below the bound
      if (!sfr.exec_in_loader && mode_r != `MODE_READ) begin
         in_range = in_range && ({1'b0, eff_addr} >= low_start);
      end
   end

   // Held off while halted, released once flash is free
   assign irq_take = irq_req && state_r == flash_seq_pkg::ST_IDLE;
   assign sfr.cpu_stall = state_r != flash_seq_pkg::ST_IDLE;
   assign sfr.sfr_rdata = rdata_r;

   always_comb begin
      ctrl_nxt = ctrl_r;
      mode_nxt = mode_r;
      adr_hi_nxt = adr_hi_r;
      adr_lo_nxt = adr_lo_r;
      data_nxt = data_r;
      low_bound_nxt = low_bound_r;
      strap_done_nxt = 1'b1;
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      mem_we = 1'b0;
      mem_addr = target[ADDR_W-1:0];
      mem_wdata = 8'hFF;
      if (!strap_done_r) begin
         low_bound_nxt = low_bound_opt;
      end
      if (sfr.sfr_wr && state_r == flash_seq_pkg::ST_IDLE) begin
         unique case (sfr.sfr_addr)
            `SFR_ACCESS_CONTROL: ctrl_nxt = sfr.sfr_wdata;
            `SFR_MODE_SELECT: mode_nxt = sfr.sfr_wdata[2:0];
            `SFR_ADDR_HIGH: adr_hi_nxt = sfr.sfr_wdata;
            `SFR_ADDR_LOW: adr_lo_nxt = sfr.sfr_wdata;
            `SFR_DATA: data_nxt = sfr.sfr_wdata;
            `SFR_LOW_BOUND: begin
               // Only application code moves the bound
               if (!sfr.exec_in_loader) begin
                  low_bound_nxt = sfr.sfr_wdata[5:0];
               end
            end
            default: ;
         endcase
      end
      unique case (state_r)
         flash_seq_pkg::ST_IDLE: begin
            cnt_nxt = '0;
            if (trigger && in_range) begin
               unique case (mode_r)
                  `MODE_ERASE: state_nxt = flash_seq_pkg::ST_ERASE;
                  `MODE_PROGRAM: state_nxt = flash_seq_pkg::ST_PROGRAM;
                  `MODE_READ: state_nxt = flash_seq_pkg::ST_READ;
                  default: state_nxt = flash_seq_pkg::ST_IDLE;
               endcase
            end
         end
         flash_seq_pkg::ST_ERASE: begin
            // Offset bits replaced by the counter so a sloppy address still sweeps its whole page
            mem_addr = {target[ADDR_W-1:`PAGE_BITS], cnt_r};
            mem_we = 1'b1;
            cnt_nxt = cnt_r + 1'b1;
            if (&cnt_r) begin
               state_nxt = flash_seq_pkg::ST_IDLE;
            end
         end
         flash_seq_pkg::ST_PROGRAM: begin
            cnt_nxt = cnt_r + 1'b1;
            if (op_done(cnt_r)) begin
               mem_we = 1'b1;
               mem_wdata = mem[target[ADDR_W-1:0]] & data_r;
               state_nxt = flash_seq_pkg::ST_IDLE;
            end
         end
         flash_seq_pkg::ST_READ: begin
            cnt_nxt = cnt_r + 1'b1;
            if (op_done(cnt_r)) begin
               data_nxt = mem[target[ADDR_W-1:0]];
               state_nxt = flash_seq_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // Read data holds until the next read strobe
   always_comb begin
      rdata_nxt = rdata_r;
      if (sfr.sfr_rd) begin
         unique case (sfr.sfr_addr)
            `SFR_ACCESS_CONTROL: rdata_nxt = ctrl_r;
            `SFR_MODE_SELECT: rdata_nxt = {5'h00, mode_r};
            `SFR_ADDR_HIGH: rdata_nxt = adr_hi_r;
            `SFR_ADDR_LOW: rdata_nxt = adr_lo_r;
            `SFR_DATA: rdata_nxt = data_r;
            `SFR_LOW_BOUND: rdata_nxt = {2'h0, low_bound_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Array has no reset; contents survive like real flash
   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         mem[mem_addr] <= mem_wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= 8'h00;
         mode_r <= 3'h0;
         adr_hi_r <= 8'h00;
         adr_lo_r <= 8'h00;
         data_r <= 8'h00;
         low_bound_r <= 6'h00;
         strap_done_r <= 1'b0;
         state_r <= flash_seq_pkg::ST_IDLE;
         cnt_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         mode_r <= mode_nxt;
         adr_hi_r <= adr_hi_nxt;
         adr_lo_r <= adr_lo_nxt;
         data_r <= data_nxt;
         low_bound_r <= low_bound_nxt;
         strap_done_r <= strap_done_nxt;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule

//--- design/flash_seq_host.sv
// Purpose: APB controller that plays the CPU side of the register port
// Assumes: One outstanding register access at a time
// Notes: for register-port accesses pready is held low while the access or a stall is in progress
`include "flash_seq_cfg.svh"
`timescale 1ns/1ps
module flash_seq_host (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   flash_sfr_if.cpu sfr
);
   flash_seq_pkg::host_state_t state_r, state_nxt;
   logic rd_r, rd_nxt;
   logic [2:0] addr_r, addr_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic [7:0] rbuf_r, rbuf_nxt;
   logic loader_r, loader_nxt;
   logic [31:0] prdata_nxt;
   logic [31:0] prdata_r;
   logic access;
   logic sfr_req;

   assign access = psel && penable;
   assign sfr_req = access && (paddr == `APB_SFR_WRITE || paddr == `APB_SFR_READ);
   // Stalled CPU takes no new register-port access; status and control accesses still complete
   assign pready = sfr_req ? (state_r == flash_seq_pkg::HS_SETTLE && !sfr.cpu_stall) : 1'b1;
   assign pslverr = 1'b0;
   assign prdata = prdata_r;
   assign sfr.sfr_wr = state_r == flash_seq_pkg::HS_ISSUE && !rd_r;
   assign sfr.sfr_rd = state_r == flash_seq_pkg::HS_ISSUE && rd_r;
   assign sfr.sfr_addr = addr_r;
   assign sfr.sfr_wdata = wdata_r;
   assign sfr.exec_in_loader = loader_r;

   always_comb begin
      state_nxt = state_r;
      rd_nxt = rd_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      rbuf_nxt = rbuf_r;
      loader_nxt = loader_r;
      prdata_nxt = prdata_r;
      unique case (state_r)
         flash_seq_pkg::HS_IDLE: begin
            if (sfr_req) begin
               // Key, mode and data writes pass straight through
               rd_nxt = paddr == `APB_SFR_READ;
               addr_nxt = pwdata[10:8];
               wdata_nxt = pwdata[7:0];
               state_nxt = flash_seq_pkg::HS_ISSUE;
            end
         end
         flash_seq_pkg::HS_ISSUE: state_nxt = flash_seq_pkg::HS_SETTLE;
         flash_seq_pkg::HS_SETTLE: begin
            if (rd_r) begin
               rbuf_nxt = sfr.sfr_rdata;
            end
            // One settle cycle lets a key write show its stall first
            if (!sfr.cpu_stall) begin
               state_nxt = flash_seq_pkg::HS_IDLE;
            end
         end
         default: state_nxt = flash_seq_pkg::HS_IDLE;
      endcase
      if (access && pwrite && paddr == `APB_CONTROL) begin
         loader_nxt = pwdata[0];
      end
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `APB_STATUS: prdata_nxt = {22'h000000, sfr.cpu_stall, state_r != flash_seq_pkg::HS_IDLE, rbuf_r};
            `APB_CONTROL: prdata_nxt = {31'h00000000, loader_r};
            default: prdata_nxt = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= flash_seq_pkg::HS_IDLE;
         rd_r <= 1'b0;
         addr_r <= 3'h0;
         wdata_r <= 8'h00;
         rbuf_r <= 8'h00;
         loader_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         state_r <= state_nxt;
         rd_r <= rd_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         rbuf_r <= rbuf_nxt;
         loader_r <= loader_nxt;
         prdata_r <= prdata_nxt;
      end
   end
endmodule

//--- design/flash_seq_pkg.sv
// Purpose: Types shared by both ends
// Assumes: Nothing
// Notes: Constants live in the cfg header
package flash_seq_pkg;
   typedef logic [2:0] sfr_addr_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROGRAM, ST_READ} seq_state_t;
   typedef enum logic [1:0] {HS_IDLE, HS_ISSUE, HS_SETTLE} host_state_t;
endpackage

//--- design/flash_sfr_if.sv
// Purpose: Register port between CPU side and sequencer
// Assumes: Single clock, one access per cycle
// Notes: Read data is valid the cycle after sfr_rd
`timescale 1ns/1ps
interface flash_sfr_if;
   logic sfr_wr;
   logic sfr_rd;
   flash_seq_pkg::sfr_addr_t sfr_addr;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic exec_in_loader;
   logic cpu_stall;
   modport dev (input sfr_wr, input sfr_rd, input sfr_addr, input sfr_wdata, input exec_in_loader,
      output sfr_rdata, output cpu_stall);
   modport cpu (output sfr_wr, output sfr_rd, output sfr_addr, output sfr_wdata, output exec_in_loader,
      input sfr_rdata, input cpu_stall);
endinterface

//--- design/key_unlock.sv
// Purpose: Two-write key detector
// Assumes: Writes arrive as one-cycle strobes
// Notes: Any other value after the first key restarts the hunt
`include "flash_seq_cfg.svh"
`timescale 1ns/1ps
module key_unlock (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic key_wr,
   input wire logic [7:0] key_data,
   input wire logic enable,
   output logic trigger
);
   logic armed_r;
   logic armed_nxt;

   always_comb begin
      armed_nxt = armed_r;
      trigger = 1'b0;
      if (!enable) begin
         armed_nxt = 1'b0;
      end else if (key_wr) begin
         if (armed_r && key_data == `KEY_SECOND) begin
            trigger = 1'b1;
            armed_nxt = 1'b0;
         end else begin
            // A stray value also drops a half-entered key
            armed_nxt = (key_data == `KEY_FIRST);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         armed_r <= 1'b0;
      end else begin
         armed_r <= armed_nxt;
      end
   end
endmodule

//--- test/flash_seq_assertions.sv
// Purpose: Timing checks on the register link between the two ends
// Assumes: One clock, reset active low
// Notes: Mode, enable and key state are tracked from link writes
`include "flash_seq_cfg.svh"
`timescale 1ns/1ps
module flash_seq_assertions (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire flash_seq_pkg::sfr_addr_t sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic exec_in_loader,
   input wire logic cpu_stall
);
   logic [2:0] mode_r, mode_nxt;
   logic en_r, en_nxt, key1_r, key1_nxt, key2;
   logic [9:0] cnt_r, cnt_nxt;
   assign key2 = sfr_wr && sfr_addr == `SFR_COMMAND_KEY && sfr_wdata == `KEY_SECOND;
   always_comb begin
      mode_nxt = mode_r;
      en_nxt = en_r;
      key1_nxt = key1_r;
      cnt_nxt = cpu_stall ? cnt_r + 10'h001 : 10'h000;
      if (sfr_wr && sfr_addr == `SFR_MODE_SELECT)
         mode_nxt = sfr_wdata[2:0];
      if (sfr_wr && sfr_addr == `SFR_ACCESS_CONTROL)
         en_nxt = sfr_wdata[`ENABLE_BIT];
      // Only key writes break a pending first key
      if (sfr_wr && sfr_addr == `SFR_COMMAND_KEY)
         key1_nxt = sfr_wdata == `KEY_FIRST;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode_r <= 3'h0;
         en_r <= 1'b0;
         key1_r <= 1'b0;
         cnt_r <= 10'h000;
      end else begin
         mode_r <= mode_nxt;
         en_r <= en_nxt;
         key1_r <= key1_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   a_stall_cause: assert property ($rose(cpu_stall) |-> $past(key2 && key1_r && en_r))
      else $error("stall without a valid key pair");
   a_key_order: assert property (key2 && !key1_r |=> !cpu_stall)
      else $error("stall after a broken key pair");
   a_enable_gate: assert property (key2 && !en_r |-> ##1 !cpu_stall)
      else $error("stall while disabled");
   a_mode_gate: assert property (key2 && !(mode_r inside {3'h1, 3'h2, 3'h3}) |=> !cpu_stall)
      else $error("stall for a reserved mode");
   a_short_len: assert property ($rose(cpu_stall) && mode_r != `MODE_ERASE |-> cpu_stall[*5] ##1 !cpu_stall)
      else $error("program or read stall length wrong");
   a_erase_len: assert property ($fell(cpu_stall) && mode_r == `MODE_ERASE |-> cnt_r == 10'h200)
      else $error("erase stall length wrong");
   a_link_quiet: assert property (cpu_stall |-> !sfr_wr && !sfr_rd)
      else $error("register access during stall");
   a_region_hold: assert property (cpu_stall && $past(cpu_stall) |-> $stable(exec_in_loader))
      else $error("execution region moved during stall");
   c_erase: cover property ($rose(cpu_stall) && mode_r == `MODE_ERASE);
   c_program: cover property ($rose(cpu_stall) && mode_r == `MODE_PROGRAM);
   c_read: cover property ($rose(cpu_stall) && mode_r == `MODE_READ);
endmodule

//--- test/tb_flash_self_program_sequencer.sv
// Purpose: Bench for the sequencer and its APB controller together
// Assumes: Loader 1.5K from option, data region from 0x3600
// Notes: Flash content is modelled only where the bench has written it
`include "flash_seq_cfg.svh"
`timescale 1ns/1ps
module tb_flash_self_program_sequencer;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq_req = 1'b0, irq_take;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'h9917;
   logic [7:0] mem [0:16383];
   int error_cnt = 0, total_checks = 0, cyc = 0, wt = 0;
   flash_sfr_if sfr ();
   flash_seq_host i_flash_seq_host (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sfr(sfr));
   flash_seq_dev i_flash_seq_dev (.clk_sys(clk_sys), .rst_b(rst_b), .sfr(sfr), .loader_size_opt(4'h3),
      .low_bound_opt(6'h36), .irq_req(irq_req), .irq_take(irq_take));
   flash_seq_assertions i_chk (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_wr(sfr.sfr_wr), .sfr_rd(sfr.sfr_rd),
      .sfr_addr(sfr.sfr_addr), .sfr_wdata(sfr.sfr_wdata), .sfr_rdata(sfr.sfr_rdata),
      .exec_in_loader(sfr.exec_in_loader), .cpu_stall(sfr.cpu_stall));
   always #5 clk_sys = ~clk_sys;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      irq_req <= cyc[2];
      // Bench takes some 3800 cycles
      if (cyc == 20000) begin
         error_cnt++;
         conclude();
      end
   end
   always @(negedge clk_sys)
      if (rst_b)
         chk({31'h0, irq_take}, {31'h0, irq_req & ~sfr.cpu_stall});
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      wt = 0;
      do begin
         @(posedge clk_sys);
         wt++;
      end while (pready !== 1'b1);
      rd = prdata;
      chk({31'h0, pslverr}, 32'h0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic sw(input logic [2:0] r, input logic [7:0] d);
      apb(1'b1, `APB_SFR_WRITE, {21'h0, r, d});
   endtask
   task automatic sr(input logic [2:0] r);
      apb(1'b1, `APB_SFR_READ, {21'h0, r, 8'h00});
      apb(1'b0, `APB_STATUS, 32'h0);
      chk({8'h0, rd[31:8]}, 32'h0);
   endtask
   task automatic go(input logic e, input logic [2:0] m, input logic [15:0] a, input logic [7:0] d, input logic t);
      sw(`SFR_ACCESS_CONTROL, {e, 7'h00});
      sw(`SFR_MODE_SELECT, {5'h00, m});
      sw(`SFR_ADDR_HIGH, a[15:8]);
      sw(`SFR_ADDR_LOW, a[7:0]);
      sw(`SFR_DATA, d);
      sw(`SFR_COMMAND_KEY, `KEY_FIRST);
      sw(`SFR_COMMAND_KEY, `KEY_SECOND);
      // Long pready wait marks a started operation
      chk({31'h0, wt > 6}, {31'h0, t});
   endtask
   task automatic rchk(input logic [15:0] a);
      go(1'b1, `MODE_READ, a, 8'h00, 1'b1);
      sr(`SFR_DATA);
      chk({24'h0, rd[7:0]}, {24'h0, mem[a[13:0]]});
   endtask
   task automatic nop(input logic e, input logic [2:0] m, input logic [15:0] a);
      go(e, m, a, 8'h5A, 1'b0);
      sr(`SFR_DATA);
      chk({24'h0, rd[7:0]}, 32'h5A);
   endtask
   task automatic erase(input logic [15:0] a);
      go(1'b1, `MODE_ERASE, a, 8'h00, 1'b1);
      for (int i = 0; i < 512; i++)
         mem[a[13:0] + i] = 8'hFF;
   endtask
   task automatic prog(input logic [15:0] a, input logic [7:0] d);
      go(1'b1, `MODE_PROGRAM, a, d, 1'b1);
      mem[a[13:0]] = mem[a[13:0]] & d;
      rchk(a);
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, `APB_STATUS, 32'h0);
      chk(rd, 32'h0);
      erase(16'h3600);
      erase(16'h3800);
      for (int i = 0; i < 6; i++) begin
         v = rnd();
         rchk({7'h1B, v[8:0]});
      end
      // Few addresses so bytes are programmed twice
      for (int i = 0; i < 12; i++) begin
         v = rnd();
         prog({12'h360, v[3:0]}, v[15:8]);
      end
      prog(16'h39FF, 8'h3C);
      nop(1'b1, `MODE_PROGRAM, 16'h3A00);
      nop(1'b1, `MODE_READ, 16'h3A00);
      nop(1'b1, `MODE_PROGRAM, 16'h35FF);
      nop(1'b0, `MODE_READ, 16'h3600);
      for (int m = 0; m < 8; m++)
         if (m == 0 || m > 3)
            nop(1'b1, 3'(m), 16'h3600);
      sw(`SFR_ACCESS_CONTROL, 8'h80);
      sw(`SFR_MODE_SELECT, `MODE_READ);
      sw(`SFR_COMMAND_KEY, `KEY_FIRST);
      sw(`SFR_COMMAND_KEY, 8'h12);
      sw(`SFR_COMMAND_KEY, `KEY_SECOND);
      chk({31'h0, wt > 6}, 32'h0);
      apb(1'b1, `APB_CONTROL, 32'h1);
      apb(1'b0, `APB_CONTROL, 32'h0);
      chk(rd, 32'h1);
      erase(16'h3400);
      prog(16'h3455, v[7:0]);
      apb(1'b1, `APB_CONTROL, 32'h0);
      sw(`SFR_LOW_BOUND, 8'h38);
      sr(`SFR_LOW_BOUND);
      chk({24'h0, rd[7:0]}, 32'h38);
      nop(1'b1, `MODE_PROGRAM, 16'h3700);
      prog(16'h3801, v[23:16]);
      sw(`SFR_ACCESS_CONTROL, 8'h00);
      conclude();
   end
endmodule
